//--- rtl/pwm_capture_group.sv
// Four-channel modulator group with dead zones and input capture
// Contract
// (R01) Four independent outputs or two complementary pairs with dead-zone units.
// (R02) Each generator has 8-bit prescaler and divider by 1,2,4,8,16.
// (R03) Each channel has 16-bit down counter for period, comparator for duty.
// (R04) Period flag set at counter zero; request only when enabled.
// (R05) Auto-reload mode reloads period at zero and keeps counting.
// (R06) One-shot mode stops at zero after one interrupt.
// (R07) Pair 0/1 enable bit 4 makes channels 0/1 complementary from timer 0.
// (R08) Pair 2/3 complementary uses timer 2 and dead-zone unit 2.
// (R09) Period and compare buffered, loaded into active copies at zero.
// (R10) Output goes high when counter equals compare value.
// (R11) Capture enable turns channel pin into capture input.
// (R12) Capture channel n uses timer n.
// (R13) Software sets up the timer before enabling capture.
// (R14) Counter copied to rising or falling latch on matching edge.
// (R15) Channel 0 rise/fall interrupts enabled by bits 1 and 2.
// (R16) Channel 1 uses bits 17 and 18; channels 2/3 second register.
// (R17) Counter n reloads when capture channel n interrupts.
// (R18) Interrupt indication bits cleared by writing one.
// (R19) Capture input should not toggle within interrupt service latency.
// (R20) Edge-aligned or center-aligned waveform selectable.
// (R21) Block emits conversion-start trigger for the converter.
// (R22) Each capture channel has own rise latch, fall latch, flag.
// (R23) Odd output inverts even, both low for dead time after transitions.
`timescale 1ns/100ps
module pwm_capture_group
  import pwm_capture_pkg::*;
#(
  parameter int NCH = NUM_CH
) (
  input  wire logic                   clk_in,                // 10 MHz clock
  input  wire logic                   resetn_in,             // Async reset, active low
  input  wire logic [31:0]            modulator_control_reg_in, // Pair enables
  input  wire logic [PRE_W-1:0]       prescale_in [2],       // Prescaler per generator
  input  wire logic [DIV_SEL_W-1:0]   div_sel_in [NCH],      // Divider per channel
  input  wire chan_cfg_s              chan_cfg_in [NCH],     // Timer setup
  input  wire logic                   period_reload_value_wr_in [NCH], // Buffer write
  input  wire logic [DZ_W-1:0]        dead_time_in [2],      // Dead time per pair
  input  wire logic [31:0]            capture_ctrl_ch01_in,  // Capture ctrl ch0/1
  input  wire logic [31:0]            capture_ctrl_ch23_in,  // Capture ctrl ch2/3
  input  wire logic [NCH-1:0]         period_irq_en_in,      // Period irq enables
  input  wire logic [NCH-1:0]         period_irq_clr_in,     // Write-one clears
  input  wire logic [NCH-1:0]         capture_irq_clr_in,    // Write-one clears
  input  wire logic [NCH-1:0]         adc_trig_en_in,        // Trigger source enable
  input  wire logic [NCH-1:0]         pin_in,                // Pin input level
  output logic [NCH-1:0]              pin_out,               // Pin output level
  output logic [NCH-1:0]              pin_oe_out,            // Pin drive enable
  output logic [NCH-1:0]              period_irq_indicator_out, // Period flags
  output logic [NCH-1:0]              capture_irq_flag_out,  // Capture flags
  output logic                        period_irq_out,        // Period request
  output logic                        capture_irq_out,       // Capture request
  output logic                        adc_start_out,         // Conversion trigger pulse
  output logic [CNT_W-1:0]            rising_capture_latch_out [NCH],  // Rise latches
  output logic [CNT_W-1:0]            falling_capture_latch_out [NCH], // Fall latches
  output logic [CNT_W-1:0]            counter_out [NCH]      // Counter values
);
  import pwm_capture_pkg::*;

  logic [NCH-1:0]   tick;
  logic [NCH-1:0]   zero_hit;
  logic [NCH-1:0]   cap_evt;
  logic [NCH-1:0]   raw_wave;
  logic [NCH-1:0]   pin_d;
  logic [NCH-1:0]   pin_prev_q;
  logic [CNT_W-1:0] cnt_q  [NCH];
  logic [CNT_W-1:0] cmp_q  [NCH];
  logic [CNT_W-1:0] per_q  [NCH];
  logic [CNT_W-1:0] pbuf_q [NCH];
  logic [CNT_W-1:0] cbuf_q [NCH];
  logic [NCH-1:0]   run_q;
  logic [NCH-1:0]   up_q;
  logic [NCH-1:0]   wave_q;
  logic [NCH-1:0]   pair_mode;
  cap_cfg_s         cap [NCH];

  // Pair selection from the control word
  assign pair_mode[0] = modulator_control_reg_in[PAIR01_DZ_BIT]; // R07
  assign pair_mode[1] = 1'b0;
  assign pair_mode[2] = modulator_control_reg_in[PAIR23_DZ_BIT]; // R08
  assign pair_mode[3] = 1'b0;

  // Capture control decode, same layout for both registers
  assign cap[0] = '{chan_cfg_in[0].enable, capture_ctrl_ch01_in[CAP_RISE_IE_LO],
                    capture_ctrl_ch01_in[CAP_FALL_IE_LO]}; // R15
  assign cap[1] = '{chan_cfg_in[1].enable, capture_ctrl_ch01_in[CAP_RISE_IE_HI],
                    capture_ctrl_ch01_in[CAP_FALL_IE_HI]}; // R16
  assign cap[2] = '{chan_cfg_in[2].enable, capture_ctrl_ch23_in[CAP_RISE_IE_LO],
                    capture_ctrl_ch23_in[CAP_FALL_IE_LO]}; // R16
  assign cap[3] = '{chan_cfg_in[3].enable, capture_ctrl_ch23_in[CAP_RISE_IE_HI],
                    capture_ctrl_ch23_in[CAP_FALL_IE_HI]}; // R16

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      logic rise;
      logic fall;
      logic cap_mode;

      // Capture enable comes from bit 0/16 of the capture control word
      assign cap_mode = (g < 2) ? capture_ctrl_ch01_in[(g % 2) * 16]
                                : capture_ctrl_ch23_in[(g % 2) * 16];

      // Pin edges, capture events and period end
      assign rise = cap_mode && pin_in[g] && !pin_prev_q[g];
      assign fall = cap_mode && !pin_in[g] && pin_prev_q[g];
      assign cap_evt[g] = (rise && cap[g].rise_ie) || (fall && cap[g].fall_ie);
      assign zero_hit[g] = tick[g] && run_q[g] && (cnt_q[g] == CNT_ZERO);

      // Each generator's prescale value is shared by its two timers
      pwm_clock_div u_div (
        .clk_in      (clk_in),
        .resetn_in   (resetn_in),
        .prescale_in (prescale_in[g / 2]),
        .div_sel_in  (div_sel_in[g]),
        .tick_out    (tick[g])
      ); // R02

      // Software buffer registers
      always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          pbuf_q[g] <= CNT_ZERO;
          cbuf_q[g] <= CNT_ZERO;
        end else if (period_reload_value_wr_in[g]) begin
          pbuf_q[g] <= chan_cfg_in[g].period; // R09
          cbuf_q[g] <= chan_cfg_in[g].compare;
        end
      end

      // Down counter, reload and one-shot stop
      always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          cnt_q[g] <= CNT_ZERO;
          per_q[g] <= CNT_ZERO;
          cmp_q[g] <= CNT_ZERO;
          run_q[g] <= 1'b0;
          up_q[g]  <= 1'b0;
        end else if (!chan_cfg_in[g].enable) begin
          run_q[g] <= 1'b0;
          cnt_q[g] <= CNT_ZERO;
          per_q[g] <= CNT_ZERO; // Re-arms a finished one-shot
          up_q[g]  <= 1'b0;
        end else if (!run_q[g]) begin
          // Start from the buffers; a finished one-shot keeps its period
          // and stays parked at zero until disabled
          if (per_q[g] == CNT_ZERO || chan_cfg_in[g].auto_reload) begin
            run_q[g] <= 1'b1;
            per_q[g] <= pbuf_q[g];
            cmp_q[g] <= cbuf_q[g];
            cnt_q[g] <= pbuf_q[g];
            up_q[g]  <= 1'b0;
          end
        end else if (cap_evt[g]) begin
          cnt_q[g] <= per_q[g]; // R17 R12
          up_q[g]  <= 1'b0;
        end else if (tick[g]) begin
          if (chan_cfg_in[g].center && up_q[g]) begin
            if (cnt_q[g] >= per_q[g]) begin
              up_q[g] <= 1'b0; // R20
              cnt_q[g] <= cnt_q[g] - CNT_ONE;
            end else begin
              cnt_q[g] <= cnt_q[g] + CNT_ONE;
            end
          end else if (cnt_q[g] == CNT_ZERO) begin
            per_q[g] <= pbuf_q[g]; // R09
            cmp_q[g] <= cbuf_q[g];
            if (chan_cfg_in[g].center) begin
              up_q[g]  <= 1'b1; // R20
              cnt_q[g] <= CNT_ONE;
            end else begin
              cnt_q[g] <= pbuf_q[g]; // R05
              up_q[g]  <= 1'b0;
            end
            if (!chan_cfg_in[g].auto_reload) begin
              run_q[g] <= 1'b0; // R06
              cnt_q[g] <= CNT_ZERO;
            end
          end else begin
            cnt_q[g] <= cnt_q[g] - CNT_ONE; // R03
          end
        end
      end

      // Raw waveform: high from compare match until period end, or until the up-count match in center mode
      always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          wave_q[g] <= 1'b0;
        end else if (!run_q[g]) begin
          wave_q[g] <= 1'b0;
        end else if (cnt_q[g] == cmp_q[g] && !up_q[g]) begin
          wave_q[g] <= 1'b1; // R10
        end else if ((zero_hit[g] && !chan_cfg_in[g].center) ||
                     (up_q[g] && cnt_q[g] == cmp_q[g])) begin
          // Center mode keeps the pulse across zero; up-count match ends it
          wave_q[g] <= 1'b0;
        end
      end

      // Previous pin level for edge detection
      always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          pin_prev_q[g] <= 1'b0;
        end else begin
          pin_prev_q[g] <= pin_in[g];
        end
      end

      // Capture latches
      always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          rising_capture_latch_out[g]  <= CNT_ZERO;
          falling_capture_latch_out[g] <= CNT_ZERO;
        end else begin
          if (rise) begin
            rising_capture_latch_out[g] <= cnt_q[g]; // R14 R22
          end
          if (fall) begin
            falling_capture_latch_out[g] <= cnt_q[g]; // R14 R22
          end
        end
      end

      // Sticky flags, set beats clear
      always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          period_irq_indicator_out[g] <= 1'b0;
          capture_irq_flag_out[g]     <= 1'b0;
        end else begin
          if (zero_hit[g]) begin
            period_irq_indicator_out[g] <= 1'b1; // R04
          end else if (period_irq_clr_in[g]) begin
            period_irq_indicator_out[g] <= 1'b0; // R18
          end
          if (cap_evt[g]) begin
            capture_irq_flag_out[g] <= 1'b1; // R22
          end else if (capture_irq_clr_in[g]) begin
            capture_irq_flag_out[g] <= 1'b0; // R18
          end
        end
      end

      // Pin data from the raw waveform; the output register forces it low in capture mode
      assign pin_d[g] = raw_wave[g];

      // Registered pin drive and enable
      always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          pin_oe_out[g] <= 1'b0;
          pin_out[g]    <= 1'b0;
        end else begin
          pin_oe_out[g] <= !cap_mode; // R11
          pin_out[g]    <= cap_mode ? 1'b0 : pin_d[g];
        end
      end

      // Live counter view
      assign counter_out[g] = cnt_q[g];
    end

    // Dead-zone units, one per pair
    for (g = 0; g < NCH; g += 2) begin : g_dz
      logic [DZ_W-1:0] dz_q;
      logic            last_q;

      always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          dz_q   <= DZ_ZERO;
          last_q <= 1'b0;
        end else begin
          last_q <= wave_q[g];
          if (wave_q[g] != last_q) begin
            dz_q <= dead_time_in[g / 2]; // R23
          end else if (dz_q != DZ_ZERO) begin
            dz_q <= dz_q - DZ_ONE;
          end
        end
      end

      // Pair mode: odd is inverse of even, both low during dead time
      always_comb begin
        if (pair_mode[g]) begin
          raw_wave[g]   = wave_q[g] && (dz_q == DZ_ZERO) && (wave_q[g] == last_q); // R01 R23
          raw_wave[g+1] = !wave_q[g] && (dz_q == DZ_ZERO) && (wave_q[g] == last_q);
        end else begin
          raw_wave[g]   = wave_q[g]; // R01
          raw_wave[g+1] = wave_q[g+1];
        end
      end
    end
  endgenerate

  // Group interrupt requests and converter trigger
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      period_irq_out  <= 1'b0;
      capture_irq_out <= 1'b0;
      adc_start_out   <= 1'b0;
    end else begin
      period_irq_out  <= |(period_irq_indicator_out & period_irq_en_in); // R04
      capture_irq_out <= |capture_irq_flag_out;
      adc_start_out   <= |(zero_hit & adc_trig_en_in); // R21
    end
  end
endmodule : pwm_capture_group

//--- rtl/pwm_capture_pkg.sv
// Package with constants and carriers for the modulator and capture group
package pwm_capture_pkg;
  localparam int NUM_CH        = 4;
  localparam int CNT_W         = 16;
  localparam int PRE_W         = 8;
  localparam int DZ_W          = 8;
  localparam int DIV_SEL_W     = 3;
  // Divider selections: 1, 1/2, 1/4, 1/8, 1/16
  localparam logic [2:0] DIV_BY_1  = 3'h4;
  localparam logic [2:0] DIV_BY_2  = 3'h0;
  localparam logic [2:0] DIV_BY_4  = 3'h1;
  localparam logic [2:0] DIV_BY_8  = 3'h2;
  localparam logic [2:0] DIV_BY_16 = 3'h3;
  localparam int DIVC_W        = 4;
  // Control word bit positions in modulator_control_reg
  localparam int PAIR01_DZ_BIT = 4;
  localparam int PAIR23_DZ_BIT = 5;
  // Capture control layout, per register covering two channels
  localparam int CAP_RISE_IE_LO = 1;
  localparam int CAP_FALL_IE_LO = 2;
  localparam int CAP_RISE_IE_HI = 17;
  localparam int CAP_FALL_IE_HI = 18;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;
  localparam logic [PRE_W-1:0] PRE_ZERO = 8'h00;
  localparam logic [DZ_W-1:0]  DZ_ZERO  = 8'h00;
  localparam logic [DZ_W-1:0]  DZ_ONE   = 8'h01;
  localparam logic [DIVC_W-1:0] DIVC_ZERO = 4'h0;
  localparam logic [DIVC_W-1:0] DIVC_ONE  = 4'h1;

  // Per-channel timer setup
  typedef struct packed {
    logic             enable;      // Timer runs
    logic             auto_reload; // 1 auto-reload, 0 one-shot
    logic             center;      // 1 center-aligned, 0 edge-aligned
    logic [CNT_W-1:0] period;      // Period buffer value
    logic [CNT_W-1:0] compare;     // Compare buffer value
  } chan_cfg_s;

  // Per-channel capture setup
  typedef struct packed {
    logic enable;   // Loaded from the channel timer enable, not read
    logic rise_ie;  // Rising-edge interrupt enable
    logic fall_ie;  // Falling-edge interrupt enable
  } cap_cfg_s;
endpackage : pwm_capture_pkg

//--- rtl/pwm_clock_div.sv
// Prescaler plus power-of-two divider producing a timer tick enable
`timescale 1ns/100ps
module pwm_clock_div
  import pwm_capture_pkg::*;
(
  input  wire logic                   clk_in,     // System clock
  input  wire logic                   resetn_in,  // Async reset, active low
  input  wire logic [PRE_W-1:0]       prescale_in, // Prescale, divide by value+1
  input  wire logic [DIV_SEL_W-1:0]   div_sel_in, // Divider selection code
  output logic                        tick_out    // One-cycle enable pulse
);
  import pwm_capture_pkg::*;

  logic [PRE_W-1:0]  pre_q;
  logic [DIVC_W-1:0] div_q;
  logic [DIVC_W-1:0] div_lim;
  logic              pre_tick;

  // Divider terminal count from selection
  always_comb begin
    case (div_sel_in)
      DIV_BY_2:  div_lim = 4'h1;
      DIV_BY_4:  div_lim = 4'h3;
      DIV_BY_8:  div_lim = 4'h7;
      DIV_BY_16: div_lim = 4'hF;
      default:   div_lim = DIVC_ZERO;
    endcase
  end

  assign pre_tick = (pre_q == PRE_ZERO);

  // Eight-bit prescaler
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pre_q <= PRE_ZERO;
    end else if (pre_tick) begin
      pre_q <= prescale_in;
    end else begin
      pre_q <= pre_q - 8'h01;
    end
  end

  // Divider stage and tick pulse
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      div_q    <= DIVC_ZERO;
      tick_out <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (pre_tick) begin
        if (div_q >= div_lim) begin
          div_q    <= DIVC_ZERO;
          tick_out <= 1'b1;
        end else begin
          div_q <= div_q + DIVC_ONE;
        end
      end
    end
  end
endmodule : pwm_clock_div

//--- sim/pwm_capture_group_properties.sv
// Concurrent checks on the modulator group ports
`timescale 1ns/100ps
module pwm_capture_group_checker
  import pwm_capture_pkg::*;
#(
  parameter int NCH = NUM_CH
) (
  input wire logic             clk_in,                    // Clock
  input wire logic             resetn_in,                 // Reset, active low
  input wire logic [31:0]      modulator_control_reg_in,  // Pair enables
  input wire logic [31:0]      capture_ctrl_ch01_in,      // Capture ctrl ch0/1
  input wire logic [31:0]      capture_ctrl_ch23_in,      // Capture ctrl ch2/3
  input wire logic [NCH-1:0]   period_irq_en_in,          // Period enables
  input wire logic [NCH-1:0]   period_irq_clr_in,         // Period clears
  input wire logic [NCH-1:0]   adc_trig_en_in,            // Trigger enables
  input wire logic [NCH-1:0]   pin_in,                    // Pin levels
  input wire logic [NCH-1:0]   pin_out,                   // Pin drive levels
  input wire logic [NCH-1:0]   pin_oe_out,                // Pin drive enables
  input wire logic [NCH-1:0]   period_irq_indicator_out,  // Period flags
  input wire logic [NCH-1:0]   capture_irq_flag_out,      // Capture flags
  input wire logic             period_irq_out,            // Period request
  input wire logic             capture_irq_out,           // Capture request
  input wire logic             adc_start_out,             // Conversion trigger
  input wire logic [CNT_W-1:0] rising_capture_latch_out [NCH],  // Rise latches
  input wire logic [CNT_W-1:0] falling_capture_latch_out [NCH]  // Fall latches
);
  import pwm_capture_pkg::*;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // Capture mode releases the pin
  cap_oe_lo_a: assert property (capture_ctrl_ch01_in[0] && $past(capture_ctrl_ch01_in[0]) |-> !pin_oe_out[0])
    else $error("pin 0 driven in capture mode");
  cap_oe_hi_a: assert property (capture_ctrl_ch23_in[16] && $past(capture_ctrl_ch23_in[16]) |-> !pin_oe_out[3])
    else $error("pin 3 driven in capture mode");
  // Flags hold until cleared, requests follow flags
  flag_sticky_a: assert property ($past(period_irq_indicator_out[0]) && !$past(period_irq_clr_in[0]) |-> period_irq_indicator_out[0])
    else $error("period flag dropped without clear");
  period_req_a: assert property (period_irq_out == |($past(period_irq_indicator_out) & $past(period_irq_en_in)))
    else $error("period request mismatch");
  cap_req_a: assert property (capture_irq_out == |$past(capture_irq_flag_out))
    else $error("capture request mismatch");
  // Latches move only after the matching pin edge
  rise_latch_a: assert property (!$stable(rising_capture_latch_out[2]) |-> $past(pin_in[2]) && !$past(pin_in[2], 2))
    else $error("rise latch changed without rising edge");
  fall_latch_a: assert property (!$stable(falling_capture_latch_out[1]) |-> !$past(pin_in[1]) && $past(pin_in[1], 2))
    else $error("fall latch changed without falling edge");
  // Complementary pairs never drive both high
  pair_lo_a: assert property (modulator_control_reg_in[PAIR01_DZ_BIT] && $past(modulator_control_reg_in[PAIR01_DZ_BIT], 2) |-> !(pin_out[0] && pin_out[1]))
    else $error("pair 0/1 both high");
  pair_hi_a: assert property (modulator_control_reg_in[PAIR23_DZ_BIT] && $past(modulator_control_reg_in[PAIR23_DZ_BIT], 2) |-> !(pin_out[2] && pin_out[3]))
    else $error("pair 2/3 both high");
  adc_cause_a: assert property (adc_start_out |-> $past(adc_trig_en_in) != 0 || $past(adc_trig_en_in, 2) != 0)
    else $error("trigger without enabled source");
endmodule : pwm_capture_group_checker

bind pwm_capture_group pwm_capture_group_checker #(.NCH(NCH)) chk_u (
  .clk_in, .resetn_in, .modulator_control_reg_in, .capture_ctrl_ch01_in,
  .capture_ctrl_ch23_in, .period_irq_en_in, .period_irq_clr_in, .adc_trig_en_in,
  .pin_in, .pin_out, .pin_oe_out, .period_irq_indicator_out, .capture_irq_flag_out,
  .period_irq_out, .capture_irq_out, .adc_start_out, .rising_capture_latch_out,
  .falling_capture_latch_out
);

//--- sim/pwm_pin_partner.sv
// Power stage load and signal source on the four pins
`timescale 1ns/100ps
module pwm_pin_partner (
  input  wire logic       clk_in,           // Clock
  input  wire logic [3:0] drv_in,           // Device pin levels
  input  wire logic [3:0] oe_in,            // Device drive enables
  input  wire logic [3:0] src_in,           // Source levels when released
  output logic [3:0]      pin_out,          // Wire level
  output int              rise_cnt_out [4]  // Driven rising edges
);
  logic [3:0] last_q;
  // Wire level from whichever party drives
  assign pin_out = (oe_in & drv_in) | (~oe_in & src_in);
  // Count pulses the stage receives
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < 4; i++) begin
      if (pin_out[i] && !last_q[i] && oe_in[i]) begin
        rise_cnt_out[i] <= rise_cnt_out[i] + 1;
      end
    end
    last_q <= pin_out;
  end
endmodule : pwm_pin_partner

//--- sim/tb_pwm_capture_group.sv
// Self-checking bench for the modulator and capture group
`timescale 1ns/100ps
module tb_pwm_capture_group;
  import pwm_capture_pkg::*;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [31:0] ctrl, cc01, cc23;
  logic [PRE_W-1:0] pre [2];
  logic [DZ_W-1:0] dz [2];
  logic [2:0] div [4];
  logic [2:0] codes [5];
  chan_cfg_s cfg [4];
  logic wr [4];
  logic [3:0] pie, pclr, cclr, aen, src, pin, pout, poe, pflag, cflag;
  logic pirq, cirq, adc;
  logic [15:0] rl [4], fl [4], cnt [4];
  int rc [4];
  int errors, checked, adcn, n, e, a0, both;
  logic saw0, saw1;
  pwm_capture_group dut_u (.clk_in, .resetn_in, .modulator_control_reg_in(ctrl),
    .prescale_in(pre), .div_sel_in(div), .chan_cfg_in(cfg), .period_reload_value_wr_in(wr),
    .dead_time_in(dz), .capture_ctrl_ch01_in(cc01), .capture_ctrl_ch23_in(cc23),
    .period_irq_en_in(pie), .period_irq_clr_in(pclr), .capture_irq_clr_in(cclr),
    .adc_trig_en_in(aen), .pin_in(pin), .pin_out(pout), .pin_oe_out(poe),
    .period_irq_indicator_out(pflag), .capture_irq_flag_out(cflag), .period_irq_out(pirq),
    .capture_irq_out(cirq), .adc_start_out(adc), .rising_capture_latch_out(rl),
    .falling_capture_latch_out(fl), .counter_out(cnt));
  pwm_pin_partner stage_u (.clk_in, .drv_in(pout), .oe_in(poe), .src_in(src),
    .pin_out(pin), .rise_cnt_out(rc));
  // Clock and trigger pulse count
  always #50 clk_in = ~clk_in;
  always @(negedge clk_in) if (adc === 1'b1) adcn++;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_in);
  endtask : cyc
  task automatic chan(input int c, input logic ar, input logic [15:0] p, input logic [15:0] cm);
    cfg[c] = '{cfg[c].enable, ar, 1'b0, p, cm};
    wr[c] = 1'b1;
    cyc(1);
    wr[c] = 1'b0;
    cfg[c].enable = 1'b1;
  endtask : chan
  task automatic await(input int c);
    for (int i = 0; i < 3000 && pflag[c] !== 1'b1; i++) cyc(1);
  endtask : await
  // Interval between flags, pulses driven meanwhile
  task automatic period(input int c);
    int r0;
    await(c);
    r0 = rc[c];
    a0 = adcn;
    pclr[c] = 1'b1;
    cyc(1);
    pclr[c] = 1'b0;
    n = 1;
    while (pflag[c] !== 1'b1 && n < 3000) begin
      cyc(1);
      n++;
    end
    e = rc[c] - r0;
  endtask : period
  task automatic setcc(input int c, input logic [2:0] b);
    if (c < 2) cc01 = 32'(b) << (16 * (c % 2));
    else cc23 = 32'(b) << (16 * (c % 2));
  endtask : setcc
  task automatic conclude();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude
  // Watchdog
  initial begin
    repeat (40000) @(posedge clk_in);
    errors++;
    conclude();
  end
  // Main sequence
  initial begin
    {ctrl, cc01, cc23} = '0;
    {pie, pclr, cclr, aen, src} = '0;
    pre = '{PRE_ZERO, PRE_ZERO};
    dz = '{DZ_ZERO, DZ_ZERO};
    codes = '{DIV_BY_1, DIV_BY_2, DIV_BY_4, DIV_BY_8, DIV_BY_16};
    for (int i = 0; i < 4; i++) begin
      cfg[i] = '0;
      wr[i] = 1'b0;
      div[i] = DIV_BY_1;
    end
    cyc(16);
    check("reset outputs", {pflag, cflag, poe}, 32'h0);
    resetn_in = 1'b1;
    cyc(2);
    pre[0] = 8'h01;
    aen[0] = 1'b1;
    pie[0] = 1'b1;
    chan(0, 1'b1, 16'h0003, 16'h0001);
    for (int k = 0; k < 5; k++) begin
      div[0] = codes[k];
      period(0);
      period(0);
      check("interval", n, 2 * (1 << k) * 4);
      check("pulses per period", e, 1);
      check("trigger seen", adcn > a0, 1);
      cyc(1);
      check("period request", pirq, 1);
    end
    pie[0] = 1'b0;
    pre[0] = PRE_ZERO;
    div[0] = DIV_BY_1;
    period(0);
    period(0);
    cyc(2);
    check("masked request", pirq, 0);
    period(0);
    chan(0, 1'b1, 16'h0009, 16'h0004);
    period(0);
    check("old period kept", n, 3);
    period(0);
    check("new period", n, 10);
    // Center-aligned: up and back down, one pulse per period
    cfg[0].center = 1'b1;
    period(0);
    period(0);
    check("center interval", n, 18);
    check("center pulses", e, 1);
    cfg[0].center = 1'b0;
    chan(1, 1'b0, 16'h0005, 16'h0002);
    await(1);
    pclr[1] = 1'b1;
    cyc(1);
    pclr[1] = 1'b0;
    cyc(30);
    check("one-shot flag", pflag[1], 0);
    check("one-shot count", cnt[1], 16'h0);
    check("one-shot pulses", rc[1], 1);
    // Complementary pairs from the even timer
    chan(2, 1'b1, 16'h0009, 16'h0004);
    for (int p = 0; p < 2; p++) begin
      ctrl[PAIR01_DZ_BIT + p] = 1'b1;
      dz[p] = 8'h02;
      {saw0, saw1, both} = '0;
      repeat (40) begin
        cyc(1);
        saw0 |= pout[2 * p];
        saw1 |= pout[2 * p + 1];
        both += int'(pout[2 * p] & pout[2 * p + 1]);
      end
      check("pair odd high", saw1 & saw0, 1);
      check("pair overlap", both, 0);
      check("pair odd driven", poe[2 * p + 1], 1);
      ctrl = '0;
    end
    // Capture on every channel
    for (int c = 0; c < 4; c++) begin
      cfg[c].enable = 1'b0;
      cyc(2);
      chan(c, 1'b1, 16'h00FF, 16'h0010);
      cyc(60);
      setcc(c, 3'b011);
      cyc(3);
      check("capture releases pin", poe[c], 0);
      src[c] = 1'b1;
      cyc(6);
      check("rise flag", cflag[c], 1);
      check("capture request", cirq, 1);
      check("rise latch", rl[c] < 16'h00F0, 1);
      cclr[c] = 1'b1;
      cyc(1);
      cclr[c] = 1'b0;
      cyc(1);
      check("flag cleared", cflag[c], 0);
      setcc(c, 3'b101);
      cyc(14);
      src[c] = 1'b0;
      cyc(6);
      check("fall flag", cflag[c], 1);
      check("reload at capture", fl[c] > rl[c], 1);
      cclr[c] = 1'b1;
      cyc(1);
      cclr[c] = 1'b0;
      cyc(20);
      src[c] = 1'b1;
      cyc(6);
      check("rise masked", cflag[c], 0);
      setcc(c, 3'b000);
      src[c] = 1'b0;
    end
    conclude();
  end
endmodule : tb_pwm_capture_group
